// File: rtl/serial_prom_config_loader.sv
// Serial configuration memory loader with manual pin control
//
// How it works
// RULE1: Serial clock is core clock divided to 2048 ns; code divides by 410 cycles, giving 2050 ns
// RULE2: Automatic read starts after every reset
// RULE3: Software can drive serial clock by hand
// RULE4: Chip select driven high while memory addressed
// RULE5: Read only if select pin strapped high
// RULE6: Software can assert chip select by hand
// RULE7: Write data output, settable by hand
// RULE8: Read data input level visible to software
// RULE9: Manual control only after automatic load ends
`timescale 1ns/10ps
module serial_prom_config_loader
    import serial_prom_pkg::*;
#(
    parameter int NUM_WORDS  = `NUM_WORDS,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
)
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    output logic                       promClockOut,
    input  wire logic                  promSelectIn,
    output logic                       promSelectOut,
    output logic                       promSelectOe,
    output logic                       promWriteDataOut,
    input  wire logic                  promReadDataIn,
    input  wire logic                  manualEnable,
    input  wire logic                  manualClock,
    input  wire logic                  manualSelect,
    input  wire logic                  manualWriteData,
    output logic                       manualReadLevel,
    output logic                       loadBusy,
    output logic                       loadDone,
    output logic                       loadSkipped,
    output logic     [`WORD_BITS-1:0]  cfgData,
    output logic                       cfgValid,
    input  wire logic                  cfgReady
);
    loader_state_t         s_r;            // Registered state
    loader_state_t         s_nxt;          // Next state
    logic                  fifoInReady;    // FIFO can take a word
    logic                  stall;          // Divider held by back-pressure
    logic                  rise;           // Serial clock goes high
    logic                  fall;           // Serial clock goes low
    logic                  inAuto;         // Automatic transfer running

    assign inAuto = (s_r.st == LD_CMD) || (s_r.st == LD_DATA);

    // Hold only at the start of a low phase, so the high phase
    // never stretches and the memory sees a clean clock
    assign stall = s_r.pushValid && !fifoInReady && (s_r.divCnt == '0);
    assign rise  = !stall && (s_r.divCnt == `DIV_W'(`PROM_HALF - 1));
    assign fall  = (s_r.divCnt == `DIV_W'(`PROM_DIV - 1));

    // Next-state logic of the whole loader
    always_comb
    begin
        s_nxt = s_r;
        // Read pin level is always visible to software
        s_nxt.rdLevel = promReadDataIn;                          // RULE8
        // A pending word leaves as soon as the FIFO takes it
        if (s_r.pushValid && fifoInReady)
        begin
            s_nxt.pushValid = 1'b0;
        end
        unique case (s_r.st)
            LD_SETTLE:
            begin
                // Select pin released for one cycle so the strap settles
                s_nxt.st    = LD_STRAP;                          // RULE2
                s_nxt.selOe = 1'b0;                              // RULE5
            end
            LD_STRAP:
            begin
                if (promSelectIn)
                begin
                    // Strapped high: address the memory
                    s_nxt.st     = LD_CMD;                       // RULE5
                    s_nxt.sel    = 1'b1;                         // RULE4
                    s_nxt.selOe  = 1'b1;
                    s_nxt.cmdSh  = `READ_CMD;
                    s_nxt.wdata  = s_nxt.cmdSh[`CMD_BITS-1];     // RULE7
                    s_nxt.divCnt = '0;
                    s_nxt.bitCnt = '0;
                end
                else
                begin
                    // Weak pull-down only: no memory, skip the read
                    s_nxt.st      = LD_DONE;                     // RULE5
                    s_nxt.busy    = 1'b0;
                    s_nxt.done    = 1'b1;
                    s_nxt.skipped = 1'b1;
                end
            end
            LD_CMD, LD_DATA:
            begin
                // Free-running divider, held at the start of a low phase while a word waits
                if (!stall)
                begin
                    s_nxt.divCnt = fall ? '0
                                   : s_r.divCnt + `DIV_W'(1);    // RULE1
                end
                if (rise)
                begin
                    s_nxt.sclk = 1'b1;                           // RULE1
                    if (s_r.st == LD_DATA)
                    begin
                        // Sample on the rising edge, MSB first
                        s_nxt.dataSh = {s_r.dataSh[`WORD_BITS-2:0],
                                        promReadDataIn};         // RULE8
                        if (s_r.bitCnt == `CNT_W'(`WORD_BITS - 1))
                        begin
                            s_nxt.pushValid = 1'b1;
                            s_nxt.bitCnt    = '0;
                            s_nxt.wordCnt   = s_r.wordCnt + `CNT_W'(1);
                            if (s_r.wordCnt == `CNT_W'(NUM_WORDS - 1))
                            begin
                                s_nxt.lastWord = 1'b1;
                            end
                        end
                        else
                        begin
                            s_nxt.bitCnt = s_r.bitCnt + `CNT_W'(1);
                        end
                    end
                end
                if (fall)
                begin
                    s_nxt.sclk = 1'b0;                           // RULE1
                    if (s_r.st == LD_CMD)
                    begin
                        // Command bits change on the falling edge
                        if (s_r.bitCnt == `CNT_W'(`CMD_BITS - 1))
                        begin
                            s_nxt.st     = LD_DATA;
                            s_nxt.bitCnt = '0;
                            s_nxt.wdata  = 1'b0;                 // RULE7
                        end
                        else
                        begin
                            s_nxt.bitCnt = s_r.bitCnt + `CNT_W'(1);
                            s_nxt.cmdSh  = s_r.cmdSh << 1;
                            s_nxt.wdata  = s_r.cmdSh[`CMD_BITS-2]; // RULE7
                        end
                    end
                    else if (s_r.lastWord)
                    begin
                        // Last word in: deselect and hand over
                        s_nxt.st   = LD_DONE;                    // RULE9
                        s_nxt.sel  = 1'b0;                       // RULE4
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                end
            end
            LD_DONE:
            begin
                // Pins belong to software only from here on
                s_nxt.manualOn = manualEnable;                   // RULE9
                if (manualEnable)
                begin
                    s_nxt.sclk  = manualClock;                   // RULE3
                    s_nxt.sel   = manualSelect;                  // RULE6
                    s_nxt.selOe = 1'b1;                          // RULE6
                    s_nxt.wdata = manualWriteData;               // RULE7
                end
                else
                begin
                    // Idle pins; a skipped load leaves select released
                    s_nxt.sclk  = 1'b0;
                    s_nxt.sel   = 1'b0;
                    s_nxt.selOe = !s_r.skipped;
                    s_nxt.wdata = 1'b0;
                end
            end
            default:
            begin
                // Illegal code: restart the load
                s_nxt    = '0;
                s_nxt.st = LD_SETTLE;
            end
        endcase
    end

    // State register; reset restarts the automatic read
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_r      <= '0;
            s_r.st   <= LD_SETTLE;                               // RULE2
            s_r.busy <= 1'b1;
            // Select held low in reset: a cut transfer ends in the memory
            s_r.selOe <= 1'b1;                                   // RULE4
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign promClockOut     = s_r.sclk;
    assign promSelectOut    = s_r.sel;
    assign promSelectOe     = s_r.selOe;
    assign promWriteDataOut = s_r.wdata;
    assign manualReadLevel  = s_r.rdLevel;
    assign loadBusy         = s_r.busy;
    assign loadDone         = s_r.done;
    assign loadSkipped      = s_r.skipped;

    // Words wait here so a slow consumer stalls the serial clock
    prom_word_fifo #(
        .WIDTH (`WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .inData   (s_r.dataSh),
        .inValid  (s_r.pushValid),
        .inReady  (fifoInReady),
        .outData  (cfgData),
        .outValid (cfgValid),
        .outReady (cfgReady)
    );

    // Helper: cycles the serial clock has been high
    logic [`DIV_W-1:0] highCnt;
    always_ff @(posedge clk)
    begin
        if (srst || !s_r.sclk)
        begin
            highCnt <= '0;
        end
        else if (ce)
        begin
            highCnt <= highCnt + `DIV_W'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_release;
        $fell(srst) ##0 ce ##1 ce;
    endsequence

    sequence s_manual;
        (s_r.st == LD_DONE) && manualEnable && ce;
    endsequence

    property p_high_phase;
        ($past(inAuto) && $fell(promClockOut))
            |-> (highCnt == `DIV_W'(`PROM_DIV - `PROM_HALF));
    endproperty
    a_high_phase: assert property (p_high_phase) // RULE1
        else $error("serial clock high phase has wrong length");

    property p_auto_start;
        s_release |=> (s_r.st == LD_CMD) || (s_r.st == LD_DONE);
    endproperty
    a_auto_start: assert property (p_auto_start) // RULE2
        else $error("automatic read did not start after reset");

    property p_manual_clock;
        s_manual |=> (promClockOut == $past(manualClock));
    endproperty
    a_manual_clock: assert property (p_manual_clock) // RULE3
        else $error("manual serial clock not followed");

    property p_select_active;
        inAuto |-> (promSelectOut && promSelectOe);
    endproperty
    a_select_active: assert property (p_select_active) // RULE4
        else $error("chip select not driven high during load");

    property p_strap_skip;
        ((s_r.st == LD_STRAP) && ce && !promSelectIn)
            |=> (loadSkipped && loadDone && !promSelectOe);
    endproperty
    a_strap_skip: assert property (p_strap_skip) // RULE5
        else $error("load not skipped with select strapped low");

    property p_manual_select;
        s_manual |=> (promSelectOe && promSelectOut == $past(manualSelect));
    endproperty
    a_manual_select: assert property (p_manual_select) // RULE6
        else $error("manual chip select not followed");

    property p_manual_wdata;
        s_manual |=> (promWriteDataOut == $past(manualWriteData));
    endproperty
    a_manual_wdata: assert property (p_manual_wdata) // RULE7
        else $error("manual write data not followed");

    property p_read_level;
        ce |=> (manualReadLevel == $past(promReadDataIn));
    endproperty
    a_read_level: assert property (p_read_level) // RULE8
        else $error("read data level not shown");

    property p_no_early_manual;
        !loadDone |-> (!s_r.manualOn && loadBusy);
    endproperty
    a_no_early_manual: assert property (p_no_early_manual) // RULE9
        else $error("manual control granted during load");
endmodule

// File: rtl/serial_prom_consts.svh
// Constants for the serial configuration memory loader
`ifndef SERIAL_PROM_CONSTS_SVH
`define SERIAL_PROM_CONSTS_SVH

// Core clock period in ns (200 MHz)
`define CLK_PERIOD_NS 5
// Serial clock period in ns: 256 periods of a 125 MHz clock
`define PROM_SCLK_PERIOD_NS 2048
// Core cycles per serial clock period, least time so rounded up
`define PROM_DIV ((`PROM_SCLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Core cycles of the low phase; the high phase takes the rest
`define PROM_HALF (`PROM_DIV / 2)
// Width of the divider counter
`define DIV_W 9
// Bits in one configuration word
`define WORD_BITS 16
// Bits in the read command shifted out before data
`define CMD_BITS 9
// Read command with start bit, opcode and address zero
`define READ_CMD 9'h180
// Default number of words loaded after reset
`define NUM_WORDS 8
// Default depth of the word FIFO
`define FIFO_DEPTH 8
// Width of bit and word counters
`define CNT_W 8

`endif

// File: rtl/serial_prom_pkg.sv
// Types for the serial configuration memory loader
package serial_prom_pkg;
`include "serial_prom_consts.svh"

    // Loader sequence, Gray coded along settle-strap-cmd-data-done
    typedef enum logic [2:0]
    {
        LD_SETTLE = 3'b000,
        LD_STRAP  = 3'b001,
        LD_CMD    = 3'b011,
        LD_DATA   = 3'b010,
        LD_DONE   = 3'b110
    } load_state_t;

    // Complete state of the loader
    typedef struct packed {
        load_state_t             st;
        logic [`DIV_W-1:0]       divCnt;
        logic [`CNT_W-1:0]       bitCnt;
        logic [`CNT_W-1:0]       wordCnt;
        logic [`WORD_BITS-1:0]   dataSh;
        logic [`CMD_BITS-1:0]    cmdSh;
        logic                    pushValid;
        logic                    lastWord;
        logic                    sclk;
        logic                    sel;
        logic                    selOe;
        logic                    wdata;
        logic                    rdLevel;
        logic                    busy;
        logic                    done;
        logic                    skipped;
        logic                    manualOn;
    } loader_state_t;
endpackage

// File: rtl/prom_word_fifo.sv
// Word FIFO between the serial loader and its consumer
`timescale 1ns/10ps
module prom_word_fifo
    import serial_prom_pkg::*;
#(
    parameter int WIDTH = `WORD_BITS,
    parameter int DEPTH = `FIFO_DEPTH
)
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    // Pointers and fill level
    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   fill;
    } fifo_state_t;

    fifo_state_t          s_r;                 // Registered state
    fifo_state_t          s_nxt;               // Next state
    logic [WIDTH-1:0]     mem [DEPTH];         // Word storage
    logic                 doWr;                // Word accepted
    logic                 doRd;                // Word delivered

    // Full and empty come straight from the fill level
    assign inReady  = (s_r.fill != (AW+1)'(DEPTH));
    assign outValid = (s_r.fill != '0);
    assign outData  = mem[s_r.rdPtr];
    assign doWr     = ce && inValid && inReady;
    assign doRd     = ce && outValid && outReady;

    // Pointer arithmetic; depth need not be a power of two
    always_comb
    begin
        s_nxt = s_r;
        if (doWr)
        begin
            s_nxt.wrPtr = (s_r.wrPtr == AW'(DEPTH - 1)) ? '0
                          : s_r.wrPtr + AW'(1);
        end
        if (doRd)
        begin
            s_nxt.rdPtr = (s_r.rdPtr == AW'(DEPTH - 1)) ? '0
                          : s_r.rdPtr + AW'(1);
        end
        s_nxt.fill = s_r.fill + (AW+1)'(doWr) - (AW+1)'(doRd);
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_r <= '0;
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clk)
    begin
        if (doWr)
        begin
            mem[s_r.wrPtr] <= inData;
        end
    end
endmodule

// File: tb/prom_model.sv
// Behavioural serial configuration memory on the loader's far side
`timescale 1ns/10ps
module prom_model
#(
    parameter int OUT_DELAY_NS = 21  // Lands off the core clock edges
)
(
    input  wire logic       sclk,
    input  wire logic       sel,
    input  wire logic       wdata,
    output logic            rdata,
    output logic [8:0]      cmdSeen
);
    int          riseCnt;  // Clock rises in the current selection
    int          k;        // Stream bit index presented next
    logic [15:0] w;        // Word holding that bit

    // Stored words: a pattern so that every word differs
    function automatic logic [15:0] mem_word(input int i);
        return 16'hA5C3 ^ (16'h0111 * i[15:0]);
    endfunction

    initial
    begin
        rdata = 1'h0;
        cmdSeen = 9'h000;
        riseCnt = 0;
    end

    // A fresh selection restarts the command shifter
    always @(posedge sel)
    begin
        riseCnt = 0;
    end

    // Command bits are taken on rises while selected
    always @(posedge sclk)
    begin
        if (sel)
        begin
            if (riseCnt < 9)
                cmdSeen = {cmdSeen[7:0], wdata};
            riseCnt = riseCnt + 1;
        end
    end

    // Data changes on falls only, late by the output delay; when not
    // selected the line drops to its pull-down level
    always @(negedge sclk or negedge sel)
    begin
        if (!sel || riseCnt < 9)
            rdata <= #(OUT_DELAY_NS) 1'h0;
        else
        begin
            k = riseCnt - 9;
            w = mem_word(k / 16);
            rdata <= #(OUT_DELAY_NS) w[15 - k % 16];
        end
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the serial configuration memory loader
`timescale 1ns/10ps
`include "serial_prom_consts.svh"
module testbench
    import serial_prom_pkg::*;
;
    localparam int NW     = 10;                      // Words: two past FIFO
    localparam int PERIOD = `PROM_DIV;               // Serial clock period
    localparam int HIGH   = `PROM_DIV - `PROM_HALF;  // High phase length
    logic        clk, srst, ce, strapUp, prevClk;
    logic        promClockOut, promSelectIn, promSelectOut, promSelectOe;
    logic        promWriteDataOut, promReadDataIn, manualReadLevel;
    logic        manualEnable, manualClock, manualSelect, manualWriteData;
    logic        loadBusy, loadDone, loadSkipped, cfgValid, cfgReady;
    logic [15:0] cfgData, w;
    logic [8:0]  cmdSeen;
    int          failCount, nChecks, riseCount, n, r;

    // Strap resistor decides the pin level while nobody drives it
    assign promSelectIn = promSelectOe ? promSelectOut : strapUp;

    serial_prom_config_loader #(.NUM_WORDS(NW), .FIFO_DEPTH(8)) DUT (
        .clk(clk), .srst(srst), .ce(ce), .promClockOut(promClockOut),
        .promSelectIn(promSelectIn), .promSelectOut(promSelectOut),
        .promSelectOe(promSelectOe), .promWriteDataOut(promWriteDataOut),
        .promReadDataIn(promReadDataIn), .manualEnable(manualEnable),
        .manualClock(manualClock), .manualSelect(manualSelect),
        .manualWriteData(manualWriteData),
        .manualReadLevel(manualReadLevel), .loadBusy(loadBusy),
        .loadDone(loadDone), .loadSkipped(loadSkipped), .cfgData(cfgData),
        .cfgValid(cfgValid), .cfgReady(cfgReady));

    prom_model PROM (.sclk(promClockOut), .sel(promSelectIn),
        .wdata(promWriteDataOut), .rdata(promReadDataIn),
        .cmdSeen(cmdSeen));

    // 200 MHz core clock
    always #2.5 clk = ~clk;

    // Counts serial clock rises seen at the core clock
    always @(posedge clk)
    begin
        prevClk <= promClockOut;
        if (srst)
            riseCount <= 0;
        else if (promClockOut && !prevClk)
            riseCount <= riseCount + 1;
    end

    // Words the memory model holds, worked out independently
    function automatic logic [15:0] exp_word(input int i);
        return 16'hA5C3 ^ (16'h0111 * i[15:0]);
    endfunction

    task automatic check_bit(input string s, input logic e, input logic g);
        nChecks++;
        if (g !== e)
        begin
            failCount++;
            $display("wrong value %s expected %b seen %b", s, e, g);
        end
    endtask

    task automatic check_word(input string s, input logic [15:0] e,
                              input logic [15:0] g);
        nChecks++;
        if (g !== e)
        begin
            failCount++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic cycles(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Bounded wait for a level, then a compare of that level
    task automatic wait_bit(input string s, ref logic x, input logic v,
                            input int lim, output int c);
        c = 0;
        while (x !== v && c < lim)
        begin
            @(posedge clk);
            c++;
        end
        check_bit(s, v, x);
    endtask

    task automatic complete_run;
        if (failCount == 0 && nChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run is near 72k cycles; this cuts a hang at 90k
    initial
    begin
        #450000;
        failCount++;
        complete_run();
    end

    initial
    begin
        clk = 1'h0; srst = 1'h1; ce = 1'h1; strapUp = 1'h1;
        manualEnable = 1'h0; manualClock = 1'h0; manualSelect = 1'h0;
        manualWriteData = 1'h0; cfgReady = 1'h0; prevClk = 1'h0;
        failCount = 0; nChecks = 0; riseCount = 0;
        for (int p = 0; p < 2; p++)
        begin
            // Reset values, then the start of an automatic read
            cycles(5);
            check_bit("reset clock", 1'h0, promClockOut);
            check_bit("reset oe", 1'h1, promSelectOe);
            check_bit("reset busy", 1'h1, loadBusy);
            check_bit("reset valid", 1'h0, cfgValid);
            srst <= 1'h0;
            wait_bit("select", promSelectOut, 1'h1, 10, n);
            check_bit("select oe", 1'h1, promSelectOe);
            check_bit("first bit", 1'h1, promWriteDataOut);
            if (p == 0)
            begin
                wait_bit("rise", promClockOut, 1'h1, 1000, n);
                wait_bit("fall", promClockOut, 1'h0, 1000, n);
                check_word("high", HIGH[15:0], n[15:0]);
                wait_bit("rise", promClockOut, 1'h1, 1000, r);
                check_word("period", PERIOD[15:0], n[15:0] + r[15:0]);
                srst <= 1'h1;
            end
        end
        // Clock enable low freezes the serial clock
        n = 0;
        while (riseCount < 20 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        r = riseCount;
        w[0] = promClockOut;
        ce <= 1'h0;
        cycles(1000);
        check_word("frozen rises", r[15:0], riseCount[15:0]);
        check_bit("frozen clock", w[0], promClockOut);
        ce <= 1'h1;
        // Full FIFO stalls the ninth word; manual inputs stay ignored
        n = 0;
        while (riseCount < 9 + 9 * 16 && n < 80000)
        begin
            @(posedge clk);
            n++;
        end
        manualEnable <= 1'h1;
        manualClock <= 1'h1;
        cycles(600);
        check_word("stall rises", 16'h0099, riseCount[15:0]);
        check_bit("stall clock", 1'h0, promClockOut);
        check_bit("stall select", 1'h1, promSelectOut);
        check_bit("stall full", 1'h1, cfgValid);
        manualEnable <= 1'h0;
        manualClock <= 1'h0;
        // Drain back to back while the last word still arrives
        cfgReady <= 1'h1;
        @(posedge clk);
        for (int i = 0; i < NW; i++)
        begin
            wait_bit("valid", cfgValid, 1'h1, 8000, n);
            check_word("config word", exp_word(i), cfgData);
            @(posedge clk);
        end
        cfgReady <= 1'h0;
        check_bit("empty", 1'h0, cfgValid);
        check_word("command", 16'h0180, {7'h00, cmdSeen});
        wait_bit("done", loadDone, 1'h1, 8000, n);
        check_bit("busy end", 1'h0, loadBusy);
        check_bit("select end", 1'h0, promSelectOut);
        check_bit("oe end", 1'h1, promSelectOe);
        check_bit("not skipped", 1'h0, loadSkipped);
        // Every manual pin combination reaches the pins
        manualEnable <= 1'h1;
        for (int i = 0; i < 8; i++)
        begin
            {manualClock, manualSelect, manualWriteData} <= i[2:0];
            cycles(2);
            check_bit("manual clock", i[2], promClockOut);
            check_bit("manual select", i[1], promSelectOut);
            check_bit("manual data", i[0], promWriteDataOut);
            check_bit("manual oe", 1'h1, promSelectOe);
        end
        // Bit-banged read of the first word's two top bits
        {manualClock, manualSelect, manualWriteData} <= 3'h0;
        cycles(3);
        manualSelect <= 1'h1;
        w = exp_word(0);
        for (int b = 9; b >= -1; b--)
        begin
            manualWriteData <= (b == 8 || b == 7) ? 1'h1 : 1'h0;
            cycles(2);
            manualClock <= (b < 9) ? 1'h1 : 1'h0;
            cycles(2);
            manualClock <= 1'h0;
            cycles(10);
            if (b == 0)
                check_bit("read level", w[15], manualReadLevel);
        end
        check_bit("read level", w[14], manualReadLevel);
        // Strap low: read skipped, no serial clock at all
        manualEnable <= 1'h0;
        strapUp <= 1'h0;
        srst <= 1'h1;
        cycles(3);
        srst <= 1'h0;
        cycles(500);
        check_bit("skipped", 1'h1, loadSkipped);
        check_bit("skip done", 1'h1, loadDone);
        check_bit("skip oe", 1'h0, promSelectOe);
        check_word("skip rises", 16'h0000, riseCount[15:0]);
        complete_run();
    end
endmodule
